// [shared/chfic_pkg.sv]
// Constants and types for the charger fault policy and status indicator block
// Behaviour
// - Overvoltage opens switch unless bit 0 set
// - Watchdog fault opens switch unless bit 1
// - Thermistor fault opens switch unless bit 2
// - Thermal shutdown opens switch unless bit 3
// - Timer fault bit 4; power-on reset only
// - Rate field selects 1, 0.5, 256, 8 Hz
// - Drive current code 1 only; others reserved, though any code written is passed to the output
// - Pattern 0: charge steady, fault flash, done off
// - Pattern 1: charge flash, fault steady, done off
// - Override bit hands indicator to software
// - Software enable gates 32-step duty field
package chfic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_DUTY   = 8'h1c;
  localparam logic [7:0] ADDR_POLICY = 8'h1d;
  localparam logic [7:0] ADDR_LEDCFG = 8'h1e;
  localparam logic [7:0] ADDR_KEY    = 8'h1f;

  localparam logic [7:0] RST_DUTY   = 8'h00;
  localparam logic [7:0] RST_POLICY = 8'h00;
  localparam logic [7:0] RST_LEDCFG = 8'h00;
  localparam logic [7:0] RST_KEY    = 8'h00;

  // Policy fields: one keep-closed bit per fault source
  localparam int NUM_FAULTS     = 5;
  localparam int POL_OVP        = 0;
  localparam int POL_WDOG       = 1;
  localparam int POL_THERM      = 2;
  localparam int POL_TSHDN      = 3;
  localparam int POL_TIMER      = 4;

  // Indicator config fields
  localparam int LED_RATE_LSB   = 0;
  localparam int LED_CUR_LSB    = 2;
  localparam int LED_PATTERN    = 4;
  localparam int LED_OVRD       = 5;

  // Duty register fields
  localparam int DUTY_LSB       = 0;
  localparam int DUTY_RAMP      = 6;
  localparam int DUTY_EN        = 7;
  localparam logic [5:0] DUTY_FULL = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint CLK_HZ     = 50_000_000;
  localparam longint PWM_STEPS  = 32;
  localparam longint RATE0_MHZ  = 1000;
  localparam longint RATE1_MHZ  = 500;
  localparam longint RATE2_MHZ  = 256000;
  localparam longint RATE3_MHZ  = 8000;
  // Cycles per duty step; rounded down so the rate never falls short
  localparam longint TICK0 = (CLK_HZ * 1000) / (PWM_STEPS * RATE0_MHZ);
  localparam longint TICK1 = (CLK_HZ * 1000) / (PWM_STEPS * RATE1_MHZ);
  localparam longint TICK2 = (CLK_HZ * 1000) / (PWM_STEPS * RATE2_MHZ);
  localparam longint TICK3 = (CLK_HZ * 1000) / (PWM_STEPS * RATE3_MHZ);

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_STEADY,
    MODE_FLASH
  } chfic_mode_t;

endpackage

// [rtl/chfic_rate_gen.sv]
// Duty-step phase generator for the status indicator
`timescale 1ns/1ns
module chfic_rate_gen #(
  parameter int unsigned TICK_R0 = 32'(chfic_pkg::TICK0),
  parameter int unsigned TICK_R1 = 32'(chfic_pkg::TICK1),
  parameter int unsigned TICK_R2 = 32'(chfic_pkg::TICK2),
  parameter int unsigned TICK_R3 = 32'(chfic_pkg::TICK3)
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_rate_sel,
  output wire logic [4:0] o_phase
);
  import chfic_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic [4:0]  phase;
  } chfic_rg_st_t;

  chfic_rg_st_t st_ff;
  chfic_rg_st_t nxt_st;
  logic [31:0]  limit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (i_rate_sel)
      2'h0:    limit = TICK_R0;
      2'h1:    limit = TICK_R1;
      2'h2:    limit = TICK_R2;
      2'h3:    limit = TICK_R3;
      default: limit = TICK_R0;
    endcase
    nxt_st = st_ff;
    // Compare with >= so a switch to a faster rate never overshoots
    if (st_ff.cnt + 32'h1 >= limit) begin
      nxt_st.cnt   = 32'h0;
      nxt_st.phase = st_ff.phase + 5'h1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
    if (i_rst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    st_ff <= nxt_st;
  end

  assign o_phase = st_ff.phase;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // A rate change may leave the count past the new limit for one cycle
  chk_step_bound: assert property ($stable(i_rate_sel) |-> st_ff.cnt < limit)
    else $error("step counter passed its limit");

endmodule

// [rtl/chfic_top.sv]
// Charger fault switch policy and status indicator configuration registers
`timescale 1ns/1ns
module chfic_top #(
  parameter int unsigned TICK_R0 = 32'(chfic_pkg::TICK0),
  parameter int unsigned TICK_R1 = 32'(chfic_pkg::TICK1),
  parameter int unsigned TICK_R2 = 32'(chfic_pkg::TICK2),
  parameter int unsigned TICK_R3 = 32'(chfic_pkg::TICK3)
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_por,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output wire logic [7:0] o_reg_rdata,
  input  wire logic       i_ovp_fault,
  input  wire logic       i_wdog_fault,
  input  wire logic       i_therm_fault,
  input  wire logic       i_tshdn_fault,
  input  wire logic       i_timer_fault,
  output wire logic       o_battery_isolation_switch_open,
  input  wire logic       i_charging,
  input  wire logic       i_chg_fault,
  input  wire logic       i_chg_done,
  output wire logic       o_indicator,
  output wire logic [1:0] o_indicator_drive_current
);
  import chfic_pkg::*;

  typedef struct packed {
    logic [7:0]  duty_cfg;
    logic [7:0]  policy;
    logic [7:0]  ind_cfg;
    logic [7:0]  key;
    logic [7:0]  rdata;
    logic        sw_open;
    logic        ind;
    logic [1:0]  cur;
    chfic_mode_t mode;
  } chfic_st_t;

  chfic_st_t              st_ff;
  chfic_st_t              nxt_st;
  logic [NUM_FAULTS-1:0]  fault_vec;
  logic [NUM_FAULTS-1:0]  open_vec;
  logic [4:0]             phase;
  logic                   any_rst;
  logic [5:0]             duty;
  logic                   pattern_sel;
  logic                   ovrd;

  ////////////////////////////////////////////////////////////////////////////
  // Fault to switch decision
  assign fault_vec = {i_timer_fault, i_tshdn_fault, i_therm_fault, i_wdog_fault, i_ovp_fault};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FAULTS; gi++) begin : g_fault
      // A set keep bit masks its fault from the switch
      assign open_vec[gi] = fault_vec[gi] & ~st_ff.policy[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Indicator timing
  assign any_rst = i_rst | i_por;

  chfic_rate_gen #(
    .TICK_R0 (TICK_R0),
    .TICK_R1 (TICK_R1),
    .TICK_R2 (TICK_R2),
    .TICK_R3 (TICK_R3)
  ) u_rate (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (any_rst),
    .i_rate_sel (st_ff.ind_cfg[LED_RATE_LSB +: 2]),
    .o_phase    (phase)
  );

  assign duty        = st_ff.duty_cfg[DUTY_LSB +: 6];
  assign pattern_sel = st_ff.ind_cfg[LED_PATTERN];
  assign ovrd        = st_ff.ind_cfg[LED_OVRD];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;

    // Register writes; reserved bits are stored but steer nothing
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_DUTY:   nxt_st.duty_cfg = i_reg_wdata;
        ADDR_POLICY: nxt_st.policy   = i_reg_wdata;
        ADDR_LEDCFG: nxt_st.ind_cfg  = i_reg_wdata;
        ADDR_KEY:    nxt_st.key      = i_reg_wdata;
        default:     nxt_st.key      = st_ff.key;
      endcase
    end

    // Read data registered; unmapped addresses read as zero
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_DUTY:   nxt_st.rdata = st_ff.duty_cfg;
        ADDR_POLICY: nxt_st.rdata = st_ff.policy;
        ADDR_LEDCFG: nxt_st.rdata = st_ff.ind_cfg;
        ADDR_KEY:    nxt_st.rdata = st_ff.key;
        default:     nxt_st.rdata = 8'h00;
      endcase
    end

    nxt_st.sw_open = |open_vec;

    // Reserved current codes are passed through; software keeps to code 1
    nxt_st.cur = st_ff.ind_cfg[LED_CUR_LSB +: 2];

    // Fault outranks done, done outranks charging
    if (i_chg_fault) begin
      nxt_st.mode = pattern_sel ? MODE_STEADY : MODE_FLASH;
    end else if (i_chg_done) begin
      nxt_st.mode = MODE_OFF;
    end else if (i_charging) begin
      nxt_st.mode = pattern_sel ? MODE_FLASH : MODE_STEADY;
    end else begin
      nxt_st.mode = MODE_OFF;
    end

    if (ovrd) begin
      nxt_st.ind = st_ff.duty_cfg[DUTY_EN] &&
                   ((duty >= DUTY_FULL) || ({1'b0, phase} < duty));
    end else begin
      case (nxt_st.mode)
        MODE_STEADY: nxt_st.ind = 1'b1;
        MODE_FLASH:  nxt_st.ind = phase[4];
        MODE_OFF:    nxt_st.ind = 1'b0;
        default:     nxt_st.ind = 1'b0;
      endcase
    end

    // Core reset spares the timer-fault bit; only power-on clears it
    if (i_por) begin
      nxt_st          = '0;
      nxt_st.duty_cfg = RST_DUTY;
      nxt_st.policy   = RST_POLICY;
      nxt_st.ind_cfg  = RST_LEDCFG;
      nxt_st.key      = RST_KEY;
    end else if (i_rst) begin
      nxt_st                = '0;
      nxt_st.duty_cfg       = RST_DUTY;
      nxt_st.policy         = RST_POLICY;
      nxt_st.policy[POL_TIMER] = st_ff.policy[POL_TIMER];
      nxt_st.ind_cfg        = RST_LEDCFG;
      nxt_st.key            = RST_KEY;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    st_ff <= nxt_st;
  end

  assign o_reg_rdata                     = st_ff.rdata;
  assign o_battery_isolation_switch_open = st_ff.sw_open;
  assign o_indicator                     = st_ff.ind;
  assign o_indicator_drive_current       = st_ff.cur;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || i_por);

  chk_ovp_opens: assert property (
    i_ovp_fault && !st_ff.policy[POL_OVP] |=> o_battery_isolation_switch_open)
    else $error("overvoltage did not open the switch");

  chk_wdog_opens: assert property (
    i_wdog_fault && !st_ff.policy[POL_WDOG] |=> o_battery_isolation_switch_open)
    else $error("watchdog fault did not open the switch");

  chk_therm_opens: assert property (
    i_therm_fault && !st_ff.policy[POL_THERM] |=> o_battery_isolation_switch_open)
    else $error("thermistor fault did not open the switch");

  chk_tshdn_opens: assert property (
    i_tshdn_fault && !st_ff.policy[POL_TSHDN] |=> o_battery_isolation_switch_open)
    else $error("thermal shutdown did not open the switch");

  chk_keep_closed: assert property (
    (fault_vec & ~st_ff.policy[NUM_FAULTS-1:0]) == '0 |=> !o_battery_isolation_switch_open)
    else $error("switch opened with every active fault masked");

  chk_timer_survives: assert property (@(posedge i_sys_clk) disable iff (i_por)
    i_rst |=> st_ff.policy[POL_TIMER] == $past(st_ff.policy[POL_TIMER]))
    else $error("core reset changed the timer-fault bit");

  chk_rate_write: assert property (
    i_reg_wr && i_reg_addr == ADDR_LEDCFG |=> st_ff.ind_cfg == $past(i_reg_wdata))
    else $error("indicator config write not stored");

  chk_current_out: assert property (
    ##1 o_indicator_drive_current == $past(st_ff.ind_cfg[LED_CUR_LSB +: 2]))
    else $error("drive current does not follow its field");

  chk_steady_on: assert property (
    !ovrd && !pattern_sel && i_charging && !i_chg_fault && !i_chg_done |=> o_indicator)
    else $error("indicator not steady while charging");

  chk_fault_steady: assert property (
    !ovrd && pattern_sel && i_chg_fault |=> o_indicator)
    else $error("indicator not steady during fault");

  chk_done_dark: assert property (
    !ovrd && !i_chg_fault && i_chg_done |=> !o_indicator)
    else $error("indicator lit in done state");

  chk_sw_gate: assert property (
    ovrd && (!st_ff.duty_cfg[DUTY_EN] || duty == 6'h00) |=> !o_indicator)
    else $error("indicator lit with software gate closed");

  chk_sw_full: assert property (
    ovrd && st_ff.duty_cfg[DUTY_EN] && duty >= DUTY_FULL |=> o_indicator)
    else $error("full duty did not light the indicator");

  chk_timer_opens: assert property (
    i_timer_fault && !st_ff.policy[POL_TIMER] |=> o_battery_isolation_switch_open)
    else $error("timer fault did not open the switch");

  chk_charge_flash: assert property (
    !ovrd && pattern_sel && i_charging && !i_chg_fault && !i_chg_done
    |=> o_indicator == $past(phase[4]))
    else $error("indicator not flashing while charging");

  chk_fault_flash: assert property (
    !ovrd && !pattern_sel && i_chg_fault |=> o_indicator == $past(phase[4]))
    else $error("indicator not flashing during fault");

  chk_idle_dark: assert property (
    !ovrd && !i_charging && !i_chg_fault && !i_chg_done |=> !o_indicator)
    else $error("indicator lit with charger idle");

  chk_sw_duty: assert property (
    ovrd && st_ff.duty_cfg[DUTY_EN] && duty < DUTY_FULL
    |=> o_indicator == ($past(phase) < $past(duty[4:0])))
    else $error("indicator on-time does not follow the duty field");

  chk_policy_write: assert property (
    i_reg_wr && i_reg_addr == ADDR_POLICY |=> st_ff.policy == $past(i_reg_wdata))
    else $error("policy write not stored");

  chk_duty_write: assert property (
    i_reg_wr && i_reg_addr == ADDR_DUTY |=> st_ff.duty_cfg == $past(i_reg_wdata))
    else $error("duty write not stored");

  chk_key_write: assert property (
    i_reg_wr && i_reg_addr == ADDR_KEY |=> st_ff.key == $past(i_reg_wdata))
    else $error("key write not stored");

  chk_policy_kept: assert property (
    !(i_reg_wr && i_reg_addr == ADDR_POLICY) |=> $stable(st_ff.policy))
    else $error("policy changed without a write");

  chk_cfg_kept: assert property (
    !(i_reg_wr && i_reg_addr == ADDR_LEDCFG) |=> $stable(st_ff.ind_cfg))
    else $error("indicator config changed without a write");

  chk_duty_kept: assert property (
    !(i_reg_wr && i_reg_addr == ADDR_DUTY) |=> $stable(st_ff.duty_cfg))
    else $error("duty changed without a write");

  chk_key_kept: assert property (
    !(i_reg_wr && i_reg_addr == ADDR_KEY) |=> $stable(st_ff.key))
    else $error("key changed without a write");

  chk_read_policy: assert property (
    i_reg_rd && i_reg_addr == ADDR_POLICY |=> o_reg_rdata == $past(st_ff.policy))
    else $error("policy read returned wrong data");

  chk_read_cfg: assert property (
    i_reg_rd && i_reg_addr == ADDR_LEDCFG |=> o_reg_rdata == $past(st_ff.ind_cfg))
    else $error("indicator config read returned wrong data");

  chk_read_duty: assert property (
    i_reg_rd && i_reg_addr == ADDR_DUTY |=> o_reg_rdata == $past(st_ff.duty_cfg))
    else $error("duty read returned wrong data");

  chk_read_key: assert property (
    i_reg_rd && i_reg_addr == ADDR_KEY |=> o_reg_rdata == $past(st_ff.key))
    else $error("key read returned wrong data");

  chk_unmapped_read: assert property (
    i_reg_rd && (i_reg_addr < ADDR_DUTY || i_reg_addr > ADDR_KEY) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");

  chk_rdata_holds: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  chk_core_rst_policy: assert property (@(posedge i_sys_clk) disable iff (i_por)
    i_rst |=> st_ff.policy[POL_TSHDN:POL_OVP] == RST_POLICY[POL_TSHDN:POL_OVP])
    else $error("core reset left a fault policy bit set");

  chk_por_clears: assert property (@(posedge i_sys_clk)
    i_por |=> st_ff.policy == RST_POLICY && st_ff.ind_cfg == RST_LEDCFG)
    else $error("power-on reset left configuration set");

endmodule

// [test/charger_fault_and_indicator_config_bench.sv]
// Self-checking bench for the charger fault policy and status indicator block
`timescale 1ns/1ns
module charger_fault_and_indicator_config_bench;
  import chfic_pkg::*;

  localparam int unsigned TK [4] = '{4, 8, 2, 3};

  logic       i_sys_clk   = 1'b0;
  logic       i_rst       = 1'b1;
  logic       i_por       = 1'b1;
  logic [7:0] i_reg_addr  = 8'h00;
  logic       i_reg_wr    = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic       i_reg_rd    = 1'b0;
  logic [4:0] faults      = 5'h00;
  logic       i_charging  = 1'b0;
  logic       i_chg_fault = 1'b0;
  logic       i_chg_done  = 1'b0;
  wire  [7:0] o_reg_rdata;
  wire        o_switch_open;
  wire        o_indicator;
  wire  [1:0] o_drive_cur;
  int         mismatches  = 0;
  int         tests_run   = 0;
  int         seed        = 9;

  always #10 i_sys_clk = ~i_sys_clk;

  chfic_top #(.TICK_R0(TK[0]), .TICK_R1(TK[1]), .TICK_R2(TK[2]), .TICK_R3(TK[3])) dut_u (
    .i_sys_clk                       (i_sys_clk),
    .i_rst                           (i_rst),
    .i_por                           (i_por),
    .i_reg_addr                      (i_reg_addr),
    .i_reg_wr                        (i_reg_wr),
    .i_reg_wdata                     (i_reg_wdata),
    .i_reg_rd                        (i_reg_rd),
    .o_reg_rdata                     (o_reg_rdata),
    .i_ovp_fault                     (faults[POL_OVP]),
    .i_wdog_fault                    (faults[POL_WDOG]),
    .i_therm_fault                   (faults[POL_THERM]),
    .i_tshdn_fault                   (faults[POL_TSHDN]),
    .i_timer_fault                   (faults[POL_TIMER]),
    .o_battery_isolation_switch_open (o_switch_open),
    .i_charging                      (i_charging),
    .i_chg_fault                     (i_chg_fault),
    .i_chg_done                      (i_chg_done),
    .o_indicator                     (o_indicator),
    .o_indicator_drive_current       (o_drive_cur)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr    = 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_rd   = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd   = 1'b0;
    @(negedge i_sys_clk);
    check(n, {24'h0, o_reg_rdata}, {24'h0, e});
  endtask

  task automatic pulse_reset(input logic por);
    @(negedge i_sys_clk);
    i_rst = 1'b1;
    i_por = por;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'b0;
    i_por = 1'b0;
  endtask

  // Counts on-cycles and rising edges; a window of whole periods makes both exact
  task automatic observe(input int n, output int hi, output int rises);
    logic prev;
    hi    = 0;
    rises = 0;
    @(negedge i_sys_clk);
    prev = o_indicator;
    for (int k = 0; k < n; k++) begin
      @(negedge i_sys_clk);
      if (o_indicator === 1'b1) begin
        hi++;
        if (prev !== 1'b1) rises++;
      end
      prev = o_indicator;
    end
  endtask

  function automatic logic exp_open(input logic [7:0] pol, input logic [4:0] f);
    return |(f & ~pol[4:0]);
  endfunction

  task automatic summarize;
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] pol;
    logic [5:0] d;
    logic       en;
    int         hi, rises, p, st;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'b0;
    i_por = 1'b0;
    for (int a = 'h1c; a <= 'h1f; a++) rd_chk("reset_value", 8'(a), 8'h00);
    wr(8'h30, 8'hff);
    rd_chk("unmapped_read", 8'h30, 8'h00);
    pol = 8'($random(seed));
    wr(ADDR_KEY, pol);
    rd_chk("key_readback", ADDR_KEY, pol);
    // Corner policies first, then random ones; reserved bits must not matter
    for (int i = 0; i < 8; i++) begin
      pol = (i == 0) ? 8'h00 : (i == 1) ? 8'h1f : (i == 2) ? 8'he0 : 8'($random(seed));
      wr(ADDR_POLICY, pol);
      for (int f = 0; f < 8; f++) begin
        @(negedge i_sys_clk);
        faults = (f < 5) ? 5'(1 << f) : 5'($random(seed));
        repeat (2) @(negedge i_sys_clk);
        check("switch_open", 32'(o_switch_open), 32'(exp_open(pol, faults)));
      end
      faults = 5'h00;
      rd_chk("policy_readback", ADDR_POLICY, pol);
    end
    // Core reset keeps only the timer-fault bit; power-on clears it
    wr(ADDR_POLICY, 8'hff);
    pulse_reset(1'b0);
    rd_chk("policy_after_core_reset", ADDR_POLICY, 8'h10);
    faults = 5'h10;
    repeat (2) @(negedge i_sys_clk);
    check("timer_kept_closed", 32'(o_switch_open), 32'h0);
    pulse_reset(1'b1);
    rd_chk("policy_after_por", ADDR_POLICY, 8'h00);
    check("timer_opens", 32'(o_switch_open), 32'h1);
    faults = 5'h00;
    // Flash period per rate code, fault flashing with pattern clear
    i_charging  = 1'b1;
    i_chg_fault = 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_LEDCFG, 8'(8'hc4 | r));
      p = 32 * TK[r];
      repeat (p) @(negedge i_sys_clk);
      check("drive_current", 32'(o_drive_cur), 32'h1);
      observe(2 * p, hi, rises);
      check("flash_rises", rises, 2);
      check("flash_on_time", hi, p);
    end
    // Both patterns against charging, fault-over-done and done
    for (int pat = 0; pat < 2; pat++) begin
      for (st = 0; st < 3; st++) begin
        wr(ADDR_LEDCFG, 8'(8'h04 | (pat << LED_PATTERN)));
        @(negedge i_sys_clk);
        i_chg_fault = (st == 1);
        i_chg_done  = (st >= 1);
        p = 32 * TK[0];
        repeat (p) @(negedge i_sys_clk);
        observe(2 * p, hi, rises);
        if (st == 2) check("done_off", hi, 0);
        else if ((st == 0) == (pat == 0)) check("steady_on", hi, 2 * p);
        else check("flashing", hi, p);
      end
    end
    // Software control ignores the charger state
    wr(ADDR_LEDCFG, 8'h25);
    p = 32 * TK[1];
    for (int i = 0; i < 8; i++) begin
      d  = (i == 0) ? 6'h00 : (i == 1) ? DUTY_FULL : (i == 2) ? 6'h3f
         : 6'(1 + ($unsigned($random(seed)) % 31));
      en = (i != 7);
      @(negedge i_sys_clk);
      i_chg_fault = 1'($random(seed));
      i_chg_done  = 1'($random(seed));
      wr(ADDR_DUTY, {en, 1'($random(seed)), d});
      repeat (p) @(negedge i_sys_clk);
      observe(p, hi, rises);
      check("duty_on_time", hi, !en ? 0 : (d >= DUTY_FULL) ? p : d * TK[1]);
    end
    wr(ADDR_LEDCFG, 8'h05);
    @(negedge i_sys_clk);
    i_chg_fault = 1'b0;
    i_chg_done  = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    observe(64, hi, rises);
    check("override_released", hi, 64);
    summarize();
  end
endmodule
